/* File: rtl/mmap_top.v */
// address generation and data-memory decode for an 8-bit core
// assumes the core presents one branch kind and one data access per cycle
`timescale 1ns/1ps
`default_nettype none
`include "mmap_defs.vh"

module mmap_top
(
  input  wire        clock_i,        // system clock
  input  wire        rst_n_i,        // synchronous reset, active low
  input  wire        step_i,         // one instruction retires this cycle
  input  wire [3:0]  branch_kind_i,  // branch kind of retiring instruction
  input  wire [10:0] branch_lit_i,   // target field from the instruction word
  input  wire [7:0]  acc_i,          // accumulator for short accumulator branches
  input  wire [6:0]  opcode_addr_i,  // low seven opcode bits, direct address
  input  wire        data_rd_i,      // data read strobe
  input  wire        data_wr_i,      // data write strobe
  input  wire [7:0]  data_wdata_i,   // data write value
  input  wire [7:0]  timer0_i,       // live timer zero count
  input  wire [7:0]  port_a_data_i,        // port a pin levels
  input  wire [7:0]  port_b_data_i,        // port b pin levels
  output reg  [10:0] pc_o,           // program fetch address
  output reg  [7:0]  data_rdata_o,   // registered read data
  output reg         timer0_wr_o,    // pulse: timer zero loaded
  output reg  [7:0]  timer0_wdata_o, // value for timer zero
  output reg  [7:0]  port_a_data_out_o,    // port a output latch
  output reg  [7:0]  port_b_data_out_o,    // port b output latch
  output reg  [7:0]  pwrctl_o,       // power control
  output reg  [7:0]  bwake_o,        // port b wakeup enable
  output reg  [7:0]  abpulldn_o,     // port a/b pulldown control
  output reg  [7:0]  bpullup_o,      // port b pullup control
  output reg  [7:0]  inten_o,        // interrupt enable
  output reg  [7:0]  intflg_o,       // interrupt flags
  output reg  [7:0]  awake_o,        // port a wakeup enable
  output reg  [7:0]  intedge_o,      // interrupt edge select
  output reg  [7:0]  tmrhi_o         // timer high bits
);

  // ****************************************
  // decode helpers
  // ****************************************

  // physical ram index: bank zero 0x20..0x7f at 0..95, bank one
  // 0x20..0x3f at 96..127; other locations fold onto these
  // only bank bit zero matters: odd banks use bank one's ram below
  // 0x40, and everything else folds onto bank zero
  function [6:0] ram_index;
    input [1:0] bank;
    input [6:0] loc;
    reg         use_b1;
    begin
      use_b1 = bank[0] && (loc < `MMAP_RAM_B1_LIMIT);
      if (use_b1)
        ram_index = loc + 7'h40;
      else
        ram_index = loc - 7'h20;
    end
  endfunction

  // a special register exists at this offset
  function is_assigned;
    input [4:0] ofs;
    begin
      case (ofs)
        `MMAP_OFS_INDIRECT, `MMAP_OFS_TIMER0, `MMAP_OFS_PCL,
        `MMAP_OFS_STATUS, `MMAP_OFS_POINTER, `MMAP_OFS_PORT_A_DATA,
        `MMAP_OFS_PORT_B_DATA, `MMAP_OFS_PWRCTL, `MMAP_OFS_BWAKE,
        `MMAP_OFS_PROGRAM_COUNTER_HIGH_BUFFER, `MMAP_OFS_ABPULLDN, `MMAP_OFS_BPULLUP,
        `MMAP_OFS_INTEN, `MMAP_OFS_INTFLG, `MMAP_OFS_AWAKE,
        `MMAP_OFS_INTEDGE, `MMAP_OFS_TMRHI:
          is_assigned = 1'b1;
        default:
          is_assigned = 1'b0;
      endcase
    end
  endfunction

  // ****************************************
  // state
  // ****************************************
  reg  [7:0]  status_reg;        // status with bank bits on top
  reg  [7:0]  pointer_reg;       // indirect pointer
  reg  [7:0]  program_counter_high_buffer_reg;        // program counter high buffer
  reg  [7:0]  ram_reg [0:127];   // general ram, 128 bytes
  reg  [10:0] pc_next;           // next program counter
  reg         push_en;           // stack push this cycle
  reg         pop_en;            // stack pop this cycle
  wire [10:0] pc_inc;            // address after current instruction
  wire [10:0] stack_top;         // top of return stack
  wire [1:0]  bank_select_bits;  // current data bank
  wire        indirect;          // access goes through the pointer
  wire [6:0]  loc;               // location within bank
  wire        is_sfr;            // location falls in special range
  wire [4:0]  sfr_ofs;           // special register offset
  wire [6:0]  ram_idx;           // physical ram slot
  wire [7:0]  acc_target;        // accumulator-relative low byte
  reg  [7:0]  rd_value;          // combinational read value
  wire        wr_sfr;            // write lands on a special register
  wire        wr_ram;            // write lands in ram

  // whole 11-bit counter, so the wrap from 0x7ff to 0x000 is natural
  assign pc_inc     = pc_o + 11'h001;
  assign bank_select_bits = status_reg[`MMAP_BANK_HI:`MMAP_BANK_LO];

  // the indirect port itself never stores anything
  assign indirect   = (opcode_addr_i == {2'b00, `MMAP_OFS_INDIRECT});
  // pointer low bits for indirect, opcode low bits for direct
  assign loc        = indirect ? pointer_reg[6:0] : opcode_addr_i;
  // special range ignores the bank entirely, so every bank sees bank zero
  assign is_sfr     = (loc < `MMAP_SFR_LIMIT);
  assign sfr_ofs    = loc[4:0];
  assign ram_idx    = ram_index(bank_select_bits, loc);
  assign acc_target = pc_o[7:0] + acc_i;
  // pointer to the port through the port reads zero and writes nothing
  assign wr_sfr     = data_wr_i && is_sfr;
  // every write outside the special range lands in ram, whatever the bank
  assign wr_ram     = data_wr_i && !is_sfr;

  // ****************************************
  // return stack
  // ****************************************
  // eight deep and wrapping: a ninth nested call loses the oldest return
  mmap_ret_stack u_stack
  (
    .clock_i     (clock_i),
    .rst_n_i     (rst_n_i),
    .push_i      (push_en),
    .pop_i       (pop_en),
    .push_data_i (pc_inc),
    .top_o       (stack_top)
  );

  // ****************************************
  // next program counter
  // ****************************************
  // rolling code words 0x00e..0x00f need no special case: they are
  // fetched like any other address; the last two words are the
  // program's concern and get no guard here
  always @*
  begin
    pc_next = pc_o;
    push_en = 1'b0;
    pop_en  = 1'b0;
    // a branch kind either pushes or pops, never both, as the stack expects
    if (step_i)
    begin
      case (branch_kind_i)
        `MMAP_BR_JUMP:
          pc_next = {program_counter_high_buffer_reg[2:1], branch_lit_i[8:0]};
        `MMAP_BR_CALL:
        begin
          pc_next = {program_counter_high_buffer_reg[2:0], branch_lit_i[7:0]};
          push_en = 1'b1;
        end
        `MMAP_BR_JUMP_ACC:
          pc_next = {program_counter_high_buffer_reg[2:0], acc_target};
        `MMAP_BR_CALL_ACC:
        begin
          pc_next = {program_counter_high_buffer_reg[2:0], acc_target};
          push_en = 1'b1;
        end
        `MMAP_BR_LJUMP:
          pc_next = branch_lit_i;
        `MMAP_BR_LONG_CALL:
        begin
          pc_next = branch_lit_i;
          push_en = 1'b1;
        end
        `MMAP_BR_RET, `MMAP_BR_RET_LIT, `MMAP_BR_RET_INT:
        begin
          pc_next = stack_top;
          pop_en  = 1'b1;
        end
        `MMAP_BR_SWI:
        begin
          pc_next = `MMAP_SWI_VEC;
          push_en = 1'b1;
        end
        `MMAP_BR_HWI:
        begin
          pc_next = `MMAP_HWI_VEC;
          push_en = 1'b1;
        end
        default:
        begin
          // a data write to the low counter byte redirects the fetch
          if (wr_sfr && (sfr_ofs == `MMAP_OFS_PCL))
            pc_next = {program_counter_high_buffer_reg[2:0], data_wdata_i};
          else
            pc_next = pc_inc;
        end
      endcase
    end
  end

  // ****************************************
  // program counter register
  // ****************************************
  always @(posedge clock_i)
  begin
    // a reset in mid-run restarts fetch at the vector, with the stack emptied
    if (!rst_n_i)
      pc_o <= `MMAP_RESET_VEC;
    else
      pc_o <= pc_next;
  end

  // ****************************************
  // read mux; general instructions see the special registers
  // ****************************************
  always @*
  begin
    rd_value = 8'h00;
    if (!is_sfr)
      rd_value = ram_reg[ram_idx];
    // holes in the special range read zero so a stray read has no effect
    else if (!is_assigned(sfr_ofs))
      rd_value = 8'h00;
    else
    begin
      case (sfr_ofs)
        `MMAP_OFS_TIMER0:   rd_value = timer0_i;
        `MMAP_OFS_PCL:      rd_value = pc_o[7:0];
        `MMAP_OFS_STATUS:   rd_value = status_reg;
        `MMAP_OFS_POINTER:  rd_value = pointer_reg;
        `MMAP_OFS_PORT_A_DATA:    rd_value = port_a_data_i;
        `MMAP_OFS_PORT_B_DATA:    rd_value = port_b_data_i;
        `MMAP_OFS_PWRCTL:   rd_value = pwrctl_o;
        `MMAP_OFS_BWAKE:    rd_value = bwake_o;
        `MMAP_OFS_PROGRAM_COUNTER_HIGH_BUFFER:   rd_value = program_counter_high_buffer_reg;
        `MMAP_OFS_ABPULLDN: rd_value = abpulldn_o;
        `MMAP_OFS_BPULLUP:  rd_value = bpullup_o;
        `MMAP_OFS_INTEN:    rd_value = inten_o;
        `MMAP_OFS_INTFLG:   rd_value = intflg_o;
        `MMAP_OFS_AWAKE:    rd_value = awake_o;
        `MMAP_OFS_INTEDGE:  rd_value = intedge_o;
        `MMAP_OFS_TMRHI:    rd_value = tmrhi_o;
        // the indirect port itself has no storage and lands here
        default:            rd_value = 8'h00;
      endcase
    end
  end

  // ****************************************
  // read data register, held between reads
  // ****************************************
  always @(posedge clock_i)
  begin
    if (!rst_n_i)
      data_rdata_o <= 8'h00;
    // held between strobes, so the core may take it any cycle later
    else if (data_rd_i)
      data_rdata_o <= rd_value;
  end

  // ****************************************
  // general ram; no reset, contents are undefined at power-up
  // ****************************************
  always @(posedge clock_i)
  begin
    if (wr_ram)
      ram_reg[ram_idx] <= data_wdata_i;
  end

  // ****************************************
  // special register writes; unassigned offsets are dropped
  // ****************************************
  always @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      status_reg     <= `MMAP_STATUS_RST;
      pointer_reg    <= `MMAP_REG_RST;
      program_counter_high_buffer_reg     <= `MMAP_REG_RST;
      timer0_wr_o    <= 1'b0;
      timer0_wdata_o <= `MMAP_REG_RST;
      port_a_data_out_o    <= `MMAP_REG_RST;
      port_b_data_out_o    <= `MMAP_REG_RST;
      pwrctl_o       <= `MMAP_REG_RST;
      bwake_o        <= `MMAP_REG_RST;
      abpulldn_o     <= `MMAP_REG_RST;
      bpullup_o      <= `MMAP_REG_RST;
      inten_o        <= `MMAP_REG_RST;
      intflg_o       <= `MMAP_REG_RST;
      awake_o        <= `MMAP_REG_RST;
      intedge_o      <= `MMAP_REG_RST;
      tmrhi_o        <= `MMAP_REG_RST;
    end
    else
    begin
      timer0_wr_o <= 1'b0;  // one-cycle pulse
      if (wr_sfr)
      begin
        case (sfr_ofs)
          `MMAP_OFS_TIMER0:
          begin
            timer0_wr_o    <= 1'b1;
            timer0_wdata_o <= data_wdata_i;
          end
          `MMAP_OFS_STATUS:   status_reg  <= data_wdata_i;
          `MMAP_OFS_POINTER:  pointer_reg <= data_wdata_i;
          `MMAP_OFS_PORT_A_DATA:    port_a_data_out_o <= data_wdata_i;
          `MMAP_OFS_PORT_B_DATA:    port_b_data_out_o <= data_wdata_i;
          `MMAP_OFS_PWRCTL:   pwrctl_o    <= data_wdata_i;
          `MMAP_OFS_BWAKE:    bwake_o     <= data_wdata_i;
          `MMAP_OFS_PROGRAM_COUNTER_HIGH_BUFFER:   program_counter_high_buffer_reg  <= data_wdata_i;
          `MMAP_OFS_ABPULLDN: abpulldn_o  <= data_wdata_i;
          `MMAP_OFS_BPULLUP:  bpullup_o   <= data_wdata_i;
          `MMAP_OFS_INTEN:    inten_o     <= data_wdata_i;
          `MMAP_OFS_INTFLG:   intflg_o    <= data_wdata_i;
          `MMAP_OFS_AWAKE:    awake_o     <= data_wdata_i;
          `MMAP_OFS_INTEDGE:  intedge_o   <= data_wdata_i;
          `MMAP_OFS_TMRHI:    tmrhi_o     <= data_wdata_i;
          // the low counter byte is steered by the fetch logic; the
          // indirect port and the holes keep nothing
          default:            status_reg  <= status_reg;
        endcase
      end
    end
  end

endmodule // mmap_top
`default_nettype wire

/* File: rtl/mmap_defs.vh */
// constants for the memory address map block: vectors, branch kinds,
// data-memory layout and register offsets
// assumes inclusion by bare name from the design files
`ifndef MMAP_DEFS_VH
`define MMAP_DEFS_VH

// program side
`define MMAP_PC_W          11
`define MMAP_RESET_VEC     11'h000
`define MMAP_SWI_VEC       11'h001
`define MMAP_HWI_VEC       11'h008
`define MMAP_ROLL_LO       11'h00e
`define MMAP_ROLL_HI       11'h00f
`define MMAP_STACK_DEPTH   8
`define MMAP_SP_W          3

// branch kinds presented by the core
`define MMAP_BR_NONE       4'h0
`define MMAP_BR_JUMP       4'h1
`define MMAP_BR_CALL       4'h2
`define MMAP_BR_JUMP_ACC   4'h3
`define MMAP_BR_CALL_ACC   4'h4
`define MMAP_BR_LJUMP      4'h5
`define MMAP_BR_LONG_CALL      4'h6
`define MMAP_BR_RET        4'h7
`define MMAP_BR_RET_LIT    4'h8
`define MMAP_BR_RET_INT    4'h9
`define MMAP_BR_SWI        4'ha
`define MMAP_BR_HWI        4'hb

// data side
`define MMAP_SFR_LIMIT     7'h20
`define MMAP_RAM_B1_LIMIT  7'h40
`define MMAP_BANK_HI       7
`define MMAP_BANK_LO       6

// register offsets
`define MMAP_OFS_INDIRECT  5'h00
`define MMAP_OFS_TIMER0    5'h01
`define MMAP_OFS_PCL       5'h02
`define MMAP_OFS_STATUS    5'h03
`define MMAP_OFS_POINTER   5'h04
`define MMAP_OFS_PORT_A_DATA     5'h05
`define MMAP_OFS_PORT_B_DATA     5'h06
`define MMAP_OFS_PWRCTL    5'h08
`define MMAP_OFS_BWAKE     5'h09
`define MMAP_OFS_PROGRAM_COUNTER_HIGH_BUFFER    5'h0a
`define MMAP_OFS_ABPULLDN  5'h0b
`define MMAP_OFS_BPULLUP   5'h0c
`define MMAP_OFS_INTEN     5'h0e
`define MMAP_OFS_INTFLG    5'h0f
`define MMAP_OFS_AWAKE     5'h15
`define MMAP_OFS_INTEDGE   5'h18
`define MMAP_OFS_TMRHI     5'h19

// reset values
`define MMAP_STATUS_RST    8'h18
`define MMAP_REG_RST       8'h00

`endif

/* File: rtl/mmap_ret_stack.v */
// hardware return stack for the memory address map block
// assumes the core never pushes and pops in the same cycle
`timescale 1ns/1ps
`default_nettype none
`include "mmap_defs.vh"

module mmap_ret_stack
(
  input  wire                   clock_i,
  input  wire                   rst_n_i,
  input  wire                   push_i,
  input  wire                   pop_i,
  input  wire [`MMAP_PC_W-1:0]  push_data_i,
  output wire [`MMAP_PC_W-1:0]  top_o
);

  reg [`MMAP_PC_W-1:0] slot_reg [0:`MMAP_STACK_DEPTH-1];  // stack slots
  reg [`MMAP_SP_W-1:0] sp_reg;                            // next free slot
  wire [`MMAP_SP_W-1:0] top_idx;                          // last pushed slot

  assign top_idx = sp_reg - 3'h1;
  assign top_o   = slot_reg[top_idx];

  // ****************************************
  // pointer; wraps like a circular stack, so overflow silently
  // overwrites the oldest entry
  // ****************************************
  always @(posedge clock_i)
  begin
    if (!rst_n_i)
      sp_reg <= 3'h0;
    else if (push_i)
      sp_reg <= sp_reg + 3'h1;
    else if (pop_i)
      sp_reg <= top_idx;
  end

  // ****************************************
  // slot storage, one slot per generated register
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < `MMAP_STACK_DEPTH; gi = gi + 1)
    begin : g_slot
      always @(posedge clock_i)
      begin
        if (!rst_n_i)
          slot_reg[gi] <= 11'h000;
        else if (push_i && (sp_reg == gi))
          slot_reg[gi] <= push_data_i;
      end
    end
  endgenerate

endmodule // mmap_ret_stack
`default_nettype wire

/* File: tb/mmap_core_model.sv */
// core-side model: one retire, one data access or both per call of cyc
// assumes the bench calls cyc through the instance path, one at a time
`timescale 1ns/1ps
`default_nettype none
module mmap_core_model
(
  input  wire logic        clock_i,  // system clock
  output var  logic        step_o,   // instruction retires
  output var  logic [3:0]  kind_o,   // branch kind
  output var  logic [10:0] lit_o,    // target field
  output var  logic [7:0]  acc_o,    // accumulator
  output var  logic [6:0]  addr_o,   // direct address
  output var  logic        rd_o,     // read strobe
  output var  logic        wr_o,     // write strobe
  output var  logic [7:0]  wdata_o   // write value
);
  // ****************************************
  // idle levels from time zero
  // ****************************************
  initial
  begin
    {step_o, kind_o, lit_o, acc_o, addr_o, rd_o, wr_o, wdata_o} = '0;
  end

  // ****************************************
  // one request held for exactly one edge
  // ****************************************
  task automatic cyc(input logic s, input logic [3:0] k, input logic [10:0] l,
                     input logic [7:0] a, input logic r, input logic w,
                     input logic [6:0] ad, input logic [7:0] d);
    @(posedge clock_i);
    {step_o, kind_o, lit_o, acc_o, rd_o, wr_o, addr_o, wdata_o} <= {s, k, l, a, r, w, ad, d};
    @(posedge clock_i);
    {step_o, rd_o, wr_o} <= 3'b000;
    // released fields turn over so a stale value never looks live
    {lit_o, addr_o, wdata_o} <= ~{l, ad, d};
    #1;
  endtask
endmodule // mmap_core_model
`default_nettype wire

/* File: tb/mmap_top_assertions.sv */
// checker for the address map top: fetch address and data-side relations
// assumes a bind onto mmap_top and a single clock domain
`timescale 1ns/1ps
`default_nettype none
module mmap_top_assertions
(
  input wire logic        clock_i,
  input wire logic        rst_n_i,
  input wire logic        step_i,
  input wire logic [3:0]  branch_kind_i,
  input wire logic [10:0] branch_lit_i,
  input wire logic [6:0]  opcode_addr_i,
  input wire logic        data_rd_i,
  input wire logic        data_wr_i,
  input wire logic [7:0]  data_wdata_i,
  input wire logic [7:0]  port_a_data_i,
  input wire logic [10:0] pc_o,
  input wire logic [7:0]  data_rdata_o,
  input wire logic        timer0_wr_o,
  input wire logic [7:0]  timer0_wdata_o,
  input wire logic [7:0]  port_a_data_out_o,
  input wire logic [7:0]  port_b_data_out_o
);
  // ****************************************
  // one clock, one synchronous reset
  // ****************************************
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i);

  // ****************************************
  // program side
  // ****************************************
  reset_vector_a: assert property ($rose(rst_n_i) |-> pc_o == 11'h000)
    else $error("pc not at reset vector");
  seq_step_a: assert property (step_i && branch_kind_i == 4'h0 && !data_wr_i |=>
    pc_o == $past(pc_o) + 11'h001) else $error("pc did not advance by one");
  pc_hold_a: assert property (!step_i |=> $stable(pc_o)) else $error("pc moved idle");
  jump_reach_a: assert property (step_i && branch_kind_i == 4'h1 |=>
    pc_o[8:0] == $past(branch_lit_i[8:0])) else $error("jump target wrong");
  call_reach_a: assert property (step_i && branch_kind_i == 4'h2 |=>
    pc_o[7:0] == $past(branch_lit_i[7:0])) else $error("call target wrong");
  long_reach_a: assert property (step_i && branch_kind_i inside {4'h5, 4'h6} |=>
    pc_o == $past(branch_lit_i)) else $error("long target wrong");
  soft_vector_a: assert property (step_i && branch_kind_i == 4'ha |=> pc_o == 11'h001)
    else $error("software vector wrong");
  hard_vector_a: assert property (step_i && branch_kind_i == 4'hb |=> pc_o == 11'h008)
    else $error("hardware vector wrong");
  call_return_a: assert property ((step_i && branch_kind_i == 4'h6) ##1 !step_i ##1
    (step_i && branch_kind_i == 4'h7) |=> pc_o == $past(pc_o, 3) + 11'h001)
    else $error("return address wrong");

  // ****************************************
  // data side
  // ****************************************
  timer_load_a: assert property (data_wr_i && opcode_addr_i == 7'h01 |=>
    timer0_wr_o && timer0_wdata_o == $past(data_wdata_i)) else $error("timer load missed");
  port_a_data_write_a: assert property (data_wr_i && opcode_addr_i == 7'h05 |=>
    port_a_data_out_o == $past(data_wdata_i)) else $error("port a latch wrong");
  port_b_data_write_a: assert property (data_wr_i && opcode_addr_i == 7'h06 |=>
    port_b_data_out_o == $past(data_wdata_i)) else $error("port b latch wrong");
  pin_read_a: assert property (data_rd_i && opcode_addr_i == 7'h05 |=>
    data_rdata_o == $past(port_a_data_i)) else $error("port a read wrong");
  unused_read_a: assert property (data_rd_i && opcode_addr_i == 7'h07 |=>
    data_rdata_o == 8'h00) else $error("unassigned read not zero");
endmodule // mmap_top_assertions

bind mmap_top mmap_top_assertions u_chk
(
  .clock_i, .rst_n_i, .step_i, .branch_kind_i, .branch_lit_i, .opcode_addr_i, .data_rd_i,
  .data_wr_i, .data_wdata_i, .port_a_data_i, .pc_o, .data_rdata_o, .timer0_wr_o, .timer0_wdata_o,
  .port_a_data_out_o, .port_b_data_out_o
);
`default_nettype wire

/* File: tb/test_mcu_memory_address_map.sv */
// self-checking bench for the memory address map block
// assumes the design, the core model and the checker are compiled first
`timescale 1ns/1ps
`default_nettype none
module test_mcu_memory_address_map;
  // ****************************************
  // signals
  // ****************************************
  logic        clock_i = 1'b0;    // 4 ns system clock
  logic        rst_n_i = 1'b0;    // held low at start
  logic [7:0]  timer0_i = 8'h3c;  // live timer count
  logic [7:0]  port_a_data_i = 8'ha5;   // port a pins
  logic [7:0]  port_b_data_i = 8'h96;   // port b pins
  wire         step_i, data_rd_i, data_wr_i;
  wire  [3:0]  branch_kind_i;
  wire  [10:0] branch_lit_i, pc_o;
  wire  [7:0]  acc_i, data_wdata_i, data_rdata_o;
  wire  [6:0]  opcode_addr_i;
  int          miscompares = 0;   // mismatches seen
  int          n_tests = 0;       // comparisons made
  logic [6:0]  regs [10] = '{7'h08, 7'h09, 7'h0a, 7'h0b, 7'h0c, 7'h0e, 7'h0f, 7'h15, 7'h18, 7'h19};
  logic [6:0]  holes [3] = '{7'h07, 7'h0d, 7'h1d};  // unassigned offsets

  always #2 clock_i = ~clock_i;

  mmap_core_model u_core
  (
    .clock_i (clock_i), .step_o (step_i), .kind_o (branch_kind_i), .lit_o (branch_lit_i),
    .acc_o (acc_i), .addr_o (opcode_addr_i), .rd_o (data_rd_i), .wr_o (data_wr_i),
    .wdata_o (data_wdata_i)
  );

  mmap_top u_dut
  (
    .clock_i, .rst_n_i, .step_i, .branch_kind_i, .branch_lit_i, .acc_i, .opcode_addr_i,
    .data_rd_i, .data_wr_i, .data_wdata_i, .timer0_i, .port_a_data_i, .port_b_data_i, .pc_o,
    .data_rdata_o, .timer0_wr_o (), .timer0_wdata_o (), .port_a_data_out_o (), .port_b_data_out_o (),
    .pwrctl_o (), .bwake_o (), .abpulldn_o (), .bpullup_o (), .inten_o (), .intflg_o (),
    .awake_o (), .intedge_o (), .tmrhi_o ()
  );

  // ****************************************
  // tasks
  // ****************************************
  task automatic stop_test;
    $display("compares %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // compare the fetch address
  task automatic cmp_pc(input logic [10:0] exp);
    n_tests++;
    if (pc_o !== exp)
    begin
      miscompares++;
      $display("ERROR %0t: pc %h, expected %h", $time, pc_o, exp);
    end
  endtask

  // retire one instruction, then check the next fetch address
  task automatic br(input logic [3:0] k, input logic [10:0] l, input logic [7:0] a,
                    input logic [10:0] exp);
    u_core.cyc(1'b1, k, l, a, 1'b0, 1'b0, 7'h00, 8'h00);
    cmp_pc(exp);
  endtask

  task automatic wr(input logic [6:0] ad, input logic [7:0] d);
    u_core.cyc(1'b0, 4'h0, 11'h000, 8'h00, 1'b0, 1'b1, ad, d);
  endtask

  // read data lands one edge after the strobe
  task automatic rd(input logic [6:0] ad, input logic [7:0] exp);
    u_core.cyc(1'b0, 4'h0, 11'h000, 8'h00, 1'b1, 1'b0, ad, 8'h00);
    n_tests++;
    if (data_rdata_o !== exp)
    begin
      miscompares++;
      $display("ERROR %0t: read %h at %h, expected %h", $time, data_rdata_o, ad, exp);
    end
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    repeat (16) @(posedge clock_i);
    rst_n_i <= 1'b1;
    rd(7'h03, 8'h18);
    // branch targets stay clear of the top two words
    br(4'h6, 11'h123, 8'h00, 11'h123);
    br(4'h7, 11'h000, 8'h00, 11'h001);
    br(4'h0, 11'h000, 8'h00, 11'h002);
    br(4'h5, 11'h00e, 8'h00, 11'h00e);
    br(4'h0, 11'h000, 8'h00, 11'h00f);
    wr(7'h0a, 8'h06);
    br(4'h1, 11'h0f0, 8'h00, 11'h6f0);
    br(4'h2, 11'h7ab, 8'h00, 11'h6ab);
    br(4'h3, 11'h000, 8'h10, 11'h6bb);
    br(4'h4, 11'h000, 8'hf0, 11'h6ab);
    br(4'h7, 11'h000, 8'h00, 11'h6bc);
    br(4'h8, 11'h000, 8'h00, 11'h6f1);
    br(4'ha, 11'h000, 8'h00, 11'h001);
    br(4'hb, 11'h000, 8'h00, 11'h008);
    br(4'h9, 11'h000, 8'h00, 11'h002);
    br(4'h9, 11'h000, 8'h00, 11'h6f2);
    // bank walk: bank 1 ram differs, bank 3 folds onto it, bank 2 onto bank 0
    wr(7'h20, 8'h5a);
    wr(7'h45, 8'hc3);
    wr(7'h03, 8'h58);
    wr(7'h20, 8'h3c);
    rd(7'h45, 8'hc3);
    rd(7'h20, 8'h3c);
    rd(7'h06, 8'h96);
    wr(7'h03, 8'h98);
    rd(7'h20, 8'h5a);
    wr(7'h03, 8'hd8);
    rd(7'h20, 8'h3c);
    wr(7'h04, 8'h20);
    rd(7'h00, 8'h3c);
    wr(7'h00, 8'h77);
    rd(7'h20, 8'h77);
    wr(7'h03, 8'h18);
    rd(7'h20, 8'h5a);
    rd(7'h05, 8'ha5);
    rd(7'h01, 8'h3c);
    wr(7'h01, 8'h81);
    wr(7'h05, 8'h42);
    foreach (regs[i])
    begin
      wr(regs[i], {1'b1, regs[i]});
      rd(regs[i], {1'b1, regs[i]});
    end
    foreach (holes[i])
    begin
      wr(holes[i], 8'hff);
      rd(holes[i], 8'h00);
    end
    wr(7'h06, 8'h3c);
    // a low counter byte write alongside a plain step redirects the fetch
    u_core.cyc(1'b1, 4'h0, 11'h000, 8'h00, 1'b0, 1'b1, 7'h02, 8'h34);
    cmp_pc(11'h234);
    rd(7'h02, 8'h34);
    // only the low seven pointer bits count, so this points at the port
    wr(7'h04, 8'h80);
    rd(7'h00, 8'h00);
    // mid-run reset: fetch restarts at the vector, the bank returns to zero
    wr(7'h03, 8'h58);
    @(posedge clock_i);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    rst_n_i <= 1'b1;
    #1;
    cmp_pc(11'h000);
    rd(7'h03, 8'h18);
    stop_test;
  end

  // the sequence needs about 160 cycles; this limit cuts a hang short
  initial
  begin
    repeat (2000) @(posedge clock_i);
    miscompares++;
    $display("ERROR %0t: watchdog expired", $time);
    stop_test;
  end
endmodule // test_mcu_memory_address_map
`default_nettype wire
